// *** include/lcs_pkg.sv ***
package lcs_pkg;
  // Operating clock prescaler choices, twelve inputs
  localparam int unsigned CLK_SEL_COUNT = 12;
  localparam logic [3:0] CLK_SEL_MAX = 4'hB;
  // Break field lengths in bit times
  localparam logic [4:0] BRK_TX_BASE = 5'h0D;
  localparam logic [4:0] BRK_RX_MIN = 5'h0B;
  // Field positions in the serial control register
  localparam int unsigned BRK_LEN_LSB = 2;
  localparam int unsigned BRK_LEN_MSB = 4;
  // Reset values
  localparam logic [7:0] RX_BUF_RST = 8'hFF;
  localparam logic [7:0] RX_SHIFT_RST = 8'hFF;
  // Extra idle before a back-to-back start bit, in clk_i cycles
  localparam logic [1:0] B2B_GAP_CLKS = 2'h2;
  // Baud clock ticks per bit (16x oversampling)
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;

  typedef struct packed {
    logic power_enable;
    logic tx_enable;
    logic rx_enable;
    logic len8;
    logic msb_first;
    logic tx_invert;
    logic brk_rx_mode;
    logic [7:0] ctrl_reg;
    logic [3:0] clk_sel;
    logic [7:0] baud_divider_control;
  } lcs_cfg_t;

  typedef struct packed {
    logic tx_done_irq;
    logic rx_irq;
    logic brk_rx_irq;
    logic overrun_error;
    logic parity_error;
    logic framing_error;
    logic tx_busy;
  } lcs_stat_t;

  typedef enum logic [1:0] {TX_IDLE, TX_GAP, TX_DATA, TX_BRK} lcs_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} lcs_rx_st_t;
endpackage

// *** logic/lcs_uart.sv ***
`timescale 1ns/1ns
// Behaviour
// - Power enable low idles all logic but synchroniser and output registers
// - Seven or eight data bits
// - Own 8-bit baud divider
// - Independent transmit and receive enables
// - Twelve selectable operating clock inputs
// - Selectable MSB or LSB first order
// - Inversion on transmit pin only
// - Break transmit of 13 to 20 bits
// - Break length from control bits 4:2
// - Low of 11+ bits is valid break
// - Shorter low: error, no interrupt, stay
// - Judge break length at stop bit
// - Break mode suppresses errors and transfers
// - Transmit done pulse per frame or break
// - Back-to-back gap stretched two clocks
// - Stopped clock holds registers and pin
// - Switch bits route receive pin internally
// - Power enable low resets all but synchroniser and output registers
// - Transmit enable low resets transmitter
// - Buffer write starts transmission
module lcs_uart
  import lcs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Configuration
  input wire lcs_cfg_t cfg_i,
  input wire logic input_switch_bit0_i,
  input wire logic input_switch_bit1_i,
  // Transmit buffer write
  input wire logic tx_wr_i,
  input wire logic [7:0] tx_buffer_i,
  // Serial line
  input wire logic serial_rx_pin_i,
  output logic serial_tx_pin_o,
  // Routed receive level
  output logic external_irq_input_o,
  output logic capture_timer_input_o,
  // Receive data and status
  output logic [7:0] rx_buffer_o,
  output lcs_stat_t stat_o
);
  // Pin synchroniser; first stage read only by second
  logic rx_s1_ff, rx_s2_ff;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
    end else begin
      rx_s1_ff <= serial_rx_pin_i;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  // Internal reset: power enable low clears prescaler, transmitter and receiver
  logic run;
  assign run = rstn_i & cfg_i.power_enable;

  // Prescaler: one of twelve operating clock rates, 2^sel
  logic [10:0] pre_ff, nxt_pre;
  logic [3:0] sel;
  logic op_tick;
  always_comb begin
    sel = (cfg_i.clk_sel > CLK_SEL_MAX) ? CLK_SEL_MAX : cfg_i.clk_sel;
    nxt_pre = pre_ff + 11'h001;
    op_tick = (sel == 4'h0) ? 1'b1 :
      (pre_ff & ((11'h001 << sel) - 11'h001)) == 11'h000;
  end

  // 8-bit baud divider gives oversample tick
  logic [7:0] bdiv_ff, nxt_bdiv;
  logic btick;
  always_comb begin
    btick = op_tick && (bdiv_ff == 8'h00);
    nxt_bdiv = bdiv_ff;
    if (op_tick) begin
      nxt_bdiv = (bdiv_ff == 8'h00) ? cfg_i.baud_divider_control :
        bdiv_ff - 8'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!run) begin
      pre_ff <= 11'h000;
      bdiv_ff <= 8'h00;
    end else begin
      pre_ff <= nxt_pre;
      bdiv_ff <= nxt_bdiv;
    end
  end

  // Transmitter; resets on transmit enable low
  lcs_tx_st_t tx_st_ff, nxt_tx_st;
  logic [8:0] tsh_ff, nxt_tsh;
  logic [3:0] tovs_ff, nxt_tovs;
  logic [4:0] tcnt_ff, nxt_tcnt;
  logic [1:0] tgap_ff, nxt_tgap;
  logic tline_ff, nxt_tline, tdone_ff, nxt_tdone;
  logic [7:0] tbuf_ff, nxt_tbuf;
  logic tpend_ff, nxt_tpend, tbrk_ff, nxt_tbrk;
  logic [4:0] brk_len;
  logic [3:0] nbits;
  logic txp_ff;
  always_comb begin
    brk_len = BRK_TX_BASE +
      {2'b00, cfg_i.ctrl_reg[BRK_LEN_MSB:BRK_LEN_LSB]};
    nbits = cfg_i.len8 ? 4'h8 : 4'h7;
    nxt_tx_st = tx_st_ff;
    nxt_tsh = tsh_ff;
    nxt_tovs = tovs_ff;
    nxt_tcnt = tcnt_ff;
    nxt_tgap = tgap_ff;
    nxt_tline = tline_ff;
    nxt_tdone = 1'b0;
    nxt_tbuf = tbuf_ff;
    nxt_tpend = tpend_ff;
    nxt_tbrk = tbrk_ff;
    if (tx_wr_i) begin
      nxt_tbuf = tx_buffer_i;
      nxt_tpend = 1'b1;
      nxt_tbrk = cfg_i.ctrl_reg[0];
    end
    case (tx_st_ff)
      TX_IDLE: begin
        nxt_tline = 1'b1;
        if (tpend_ff && btick) begin
          nxt_tpend = tx_wr_i;
          nxt_tovs = 4'h0;
          nxt_tline = 1'b0;
          if (tbrk_ff) begin
            nxt_tcnt = brk_len;
            nxt_tx_st = TX_BRK;
          end else begin
            // Line order in 8:1, stop in 0; unused eighth bit sent high
            nxt_tsh = cfg_i.msb_first ? {tbuf_ff, 1'b1} :
              {tbuf_ff[0], tbuf_ff[1], tbuf_ff[2], tbuf_ff[3],
               tbuf_ff[4], tbuf_ff[5], tbuf_ff[6], tbuf_ff[7], 1'b1};
            if (!cfg_i.len8) nxt_tsh[1] = 1'b1;
            nxt_tcnt = {1'b0, nbits} + 5'h01;
            nxt_tx_st = TX_DATA;
          end
        end
      end
      TX_GAP: begin
        // Two extra clocks before a back-to-back start
        nxt_tgap = tgap_ff - 2'h1;
        if (tgap_ff == 2'h1) nxt_tx_st = TX_IDLE;
      end
      TX_DATA: begin
        if (btick) begin
          nxt_tovs = tovs_ff + 4'h1;
          if (tovs_ff == OVS_LAST) begin
            nxt_tline = tsh_ff[8];
            nxt_tsh = {tsh_ff[7:0], 1'b1};
            nxt_tcnt = tcnt_ff - 5'h01;
            if (tcnt_ff == 5'h00) begin
              nxt_tdone = 1'b1;
              nxt_tgap = B2B_GAP_CLKS;
              nxt_tx_st = tpend_ff ? TX_GAP : TX_IDLE;
            end
          end
        end
      end
      TX_BRK: begin
        if (btick) begin
          nxt_tovs = tovs_ff + 4'h1;
          if (tovs_ff == OVS_LAST) begin
            nxt_tcnt = tcnt_ff - 5'h01;
            if (tcnt_ff == 5'h01) nxt_tline = 1'b1;
            if (tcnt_ff == 5'h00) begin
              nxt_tdone = 1'b1;
              nxt_tx_st = TX_IDLE;
            end
          end
        end
      end
      default: nxt_tx_st = TX_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (!run || !cfg_i.tx_enable) begin
      tx_st_ff <= TX_IDLE;
      tsh_ff <= 9'h1FF;
      tovs_ff <= 4'h0;
      tcnt_ff <= 5'h00;
      tgap_ff <= 2'h0;
      tline_ff <= 1'b1;
      tdone_ff <= 1'b0;
      tbuf_ff <= 8'hFF;
      tpend_ff <= 1'b0;
      tbrk_ff <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tsh_ff <= nxt_tsh;
      tovs_ff <= nxt_tovs;
      tcnt_ff <= nxt_tcnt;
      tgap_ff <= nxt_tgap;
      tline_ff <= nxt_tline;
      tdone_ff <= nxt_tdone;
      tbuf_ff <= nxt_tbuf;
      tpend_ff <= nxt_tpend;
      tbrk_ff <= nxt_tbrk;
    end
  end
  // Pin register; inversion only here, never on receive
  always_ff @(posedge clk_i) begin
    if (!rstn_i) txp_ff <= 1'b1;
    else txp_ff <= cfg_i.tx_invert ? ~tline_ff : tline_ff;
  end

  // Receiver
  lcs_rx_st_t rx_st_ff, nxt_rx_st;
  logic [7:0] rsh_ff, nxt_rsh, rbuf_ff, nxt_rbuf;
  logic [3:0] rovs_ff, nxt_rovs, rbit_ff, nxt_rbit;
  logic [4:0] rlow_ff, nxt_rlow;
  logic rfull_ff, nxt_rfull;
  logic ove_ff, nxt_ove, fe_ff, nxt_fe, rirq_ff, nxt_rirq;
  logic birq_ff, nxt_birq, brk_fail;
  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rsh = rsh_ff;
    nxt_rbuf = rbuf_ff;
    nxt_rovs = rovs_ff;
    nxt_rbit = rbit_ff;
    nxt_rlow = rlow_ff;
    nxt_rfull = rfull_ff;
    nxt_ove = ove_ff;
    nxt_fe = fe_ff;
    nxt_rirq = 1'b0;
    nxt_birq = 1'b0;
    brk_fail = 1'b0;
    if (cfg_i.rx_enable && btick) begin
      nxt_rovs = rovs_ff + 4'h1;
      case (rx_st_ff)
        RX_IDLE: begin
          nxt_rovs = 4'h0;
          nxt_rlow = 5'h00;
          if (!rx_s2_ff) nxt_rx_st = RX_START;
        end
        RX_START: if (rovs_ff == OVS_MID) begin
          nxt_rovs = 4'h0;
          nxt_rbit = 4'h0;
          nxt_rlow = 5'h01;
          nxt_rx_st = rx_s2_ff ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rovs_ff == OVS_LAST) begin
          if (!rx_s2_ff && rlow_ff == {1'b0, rbit_ff} + 5'h01 &&
              rlow_ff != 5'h1F)
            nxt_rlow = rlow_ff + 5'h01;
          if (!cfg_i.brk_rx_mode) begin
            nxt_rsh = cfg_i.msb_first ? {rsh_ff[6:0], rx_s2_ff} :
              {rx_s2_ff, rsh_ff[7:1]};
          end
          nxt_rbit = rbit_ff + 4'h1;
          // Break mode keeps sampling past the data bits
          if (cfg_i.brk_rx_mode) begin
            if (rx_s2_ff) nxt_rx_st = RX_STOP;
          end else if (rbit_ff + 4'h1 == (cfg_i.len8 ? 4'h8 : 4'h7)) begin
            nxt_rx_st = RX_STOP;
          end
        end
        // Data frames wait for mid stop bit before judging it
        RX_STOP: if (cfg_i.brk_rx_mode || rovs_ff == OVS_LAST) begin
          nxt_rx_st = RX_IDLE;
          if (cfg_i.brk_rx_mode) begin
            if (rlow_ff >= BRK_RX_MIN) nxt_birq = 1'b1;
            else brk_fail = 1'b1;
          end else begin
            nxt_fe = ~rx_s2_ff;
            nxt_rirq = 1'b1;
            if (rfull_ff) nxt_ove = 1'b1;
            else begin
              nxt_rfull = 1'b1;
              nxt_rbuf = cfg_i.len8 ? rsh_ff : (cfg_i.msb_first ?
                {rsh_ff[6:0], 1'b0} : {1'b0, rsh_ff[7:1]});
            end
            nxt_rsh = RX_SHIFT_RST;
          end
        end
        default: nxt_rx_st = RX_IDLE;
      endcase
    end
    if (!cfg_i.rx_enable) begin
      nxt_rx_st = RX_IDLE;
      nxt_rfull = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!run) begin
      rx_st_ff <= RX_IDLE;
      rsh_ff <= RX_SHIFT_RST;
      rbuf_ff <= RX_BUF_RST;
      rovs_ff <= 4'h0;
      rbit_ff <= 4'h0;
      rlow_ff <= 5'h00;
      rfull_ff <= 1'b0;
      ove_ff <= 1'b0;
      fe_ff <= 1'b0;
      rirq_ff <= 1'b0;
      birq_ff <= 1'b0;
    end else begin
      rx_st_ff <= nxt_rx_st;
      rsh_ff <= nxt_rsh;
      rbuf_ff <= nxt_rbuf;
      rovs_ff <= nxt_rovs;
      rbit_ff <= nxt_rbit;
      rlow_ff <= nxt_rlow;
      rfull_ff <= nxt_rfull;
      ove_ff <= nxt_ove;
      fe_ff <= nxt_fe;
      rirq_ff <= nxt_rirq;
      birq_ff <= nxt_birq;
    end
  end

  // Output registers, receive level routed by switch bits
  logic eirq_ff, ctin_ff;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      eirq_ff <= 1'b1;
      ctin_ff <= 1'b1;
    end else begin
      eirq_ff <= input_switch_bit0_i ? rx_s2_ff : 1'b1;
      ctin_ff <= input_switch_bit1_i ? rx_s2_ff : 1'b1;
    end
  end
  assign serial_tx_pin_o = txp_ff;
  assign external_irq_input_o = eirq_ff;
  assign capture_timer_input_o = ctin_ff;
  assign rx_buffer_o = rbuf_ff;
  assign stat_o = '{tx_done_irq: tdone_ff, rx_irq: rirq_ff,
    brk_rx_irq: birq_ff, overrun_error: ove_ff, parity_error: 1'b0,
    framing_error: fe_ff, tx_busy: (tx_st_ff != TX_IDLE)};

  a_tx_idle_high: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!run && !cfg_i.tx_invert) |=> ##1 serial_tx_pin_o)
    else $error("tx pin not idle high");
  a_brk_short_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    brk_fail |=> !birq_ff)
    else $error("short break raised irq");
  a_brk_no_xfer: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (run && cfg_i.brk_rx_mode && $past(cfg_i.brk_rx_mode) && $past(run))
    |-> $stable(rbuf_ff))
    else $error("buffer changed in break mode");
  a_power_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !cfg_i.power_enable |=> rbuf_ff == RX_BUF_RST && !ove_ff)
    else $error("power off did not reset");
  a_txe_resets: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !cfg_i.tx_enable |=> tx_st_ff == TX_IDLE && !tdone_ff)
    else $error("tx enable low did not reset");
  a_brk_irq_len: assert property (@(posedge clk_i) disable iff (!rstn_i)
    birq_ff |-> $past(rlow_ff) >= BRK_RX_MIN)
    else $error("break irq on short low");
  a_done_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tdone_ff |=> !tdone_ff)
    else $error("tx done longer than one cycle");
  a_tx_start_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (tx_st_ff == TX_IDLE && $past(tx_st_ff) == TX_IDLE && run &&
     nxt_tx_st != TX_IDLE) |=> !tline_ff)
    else $error("frame did not start low");
endmodule

// *** testbench/lcs_remote_node.sv ***
`timescale 1ns/1ns
// Far-end node: drives the receive line, decodes the transmit line
module lcs_remote_node (
  // Clock
  input wire logic clk_i,
  // Serial line
  input wire logic line_i,
  output logic line_o
);
  int bit_cyc = 16;
  int low_cyc = 0;
  int hi_cyc = 0;
  int run = 0;
  logic prev = 1'b1;
  logic [7:0] raw;
  logic [7:0] rx_q[$];

  initial line_o = 1'b1;

  // Run lengths of the transmit line, in cycles
  always @(posedge clk_i) begin
    if (line_i !== prev) begin
      if (prev)
        hi_cyc <= run;
      else
        low_cyc <= run;
      run <= 1;
    end else begin
      run <= run + 1;
    end
    prev <= line_i;
  end

  // Decoder: low start, mid-bit samples; stop is raw bit 7 in 7-bit mode
  initial forever begin
    @(negedge line_i);
    repeat (bit_cyc / 2) @(posedge clk_i);
    if (line_i === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk_i);
        raw[i] = line_i;
      end
      rx_q.push_back(raw);
    end
    wait (line_i === 1'b1);
  end

  // One frame, first bit in b[0]; ends with two bit times of idle
  task automatic send(input logic [7:0] b, input int n);
    @(negedge clk_i);
    line_o = 1'b0;
    repeat (bit_cyc) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      line_o = b[i];
      repeat (bit_cyc) @(negedge clk_i);
    end
    line_o = 1'b1;
    repeat (bit_cyc * 2) @(negedge clk_i);
  endtask
endmodule

// *** testbench/lcs_uart_tb.sv ***
`timescale 1ns/1ns
// Self-checking bench for the serial block
module lcs_uart_tb;
  import lcs_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  lcs_cfg_t cfg = '0;
  logic tx_wr = 1'b0;
  logic [7:0] tx_d = 8'h00;
  logic isw0 = 1'b0;
  logic isw1 = 1'b0;
  logic tx_pin, rx_pin, ext_o, cap_o;
  logic [7:0] rxb, d, last_rx;
  lcs_stat_t stat;
  int mismatches = 0;
  int tests_run = 0;
  int n_txd = 0;
  int n_rx = 0;
  int n_brk = 0;
  int cyc = 0;
  int bit_c = 16;
  int n, k, r;

  lcs_uart u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg),
    .input_switch_bit0_i(isw0), .input_switch_bit1_i(isw1),
    .tx_wr_i(tx_wr), .tx_buffer_i(tx_d),
    .serial_rx_pin_i(rx_pin), .serial_tx_pin_o(tx_pin),
    .external_irq_input_o(ext_o), .capture_timer_input_o(cap_o),
    .rx_buffer_o(rxb), .stat_o(stat)
  );

  lcs_remote_node u_node (.clk_i(clk_i), .line_i(tx_pin), .line_o(rx_pin));

  initial forever #4 clk_i = ~clk_i;

  // Pulse counters and hang guard
  always @(posedge clk_i) begin
    if (stat.tx_done_irq === 1'b1)
      n_txd++;
    if (stat.rx_irq === 1'b1)
      n_rx++;
    if (stat.brk_rx_irq === 1'b1)
      n_brk++;
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Line order of a character, unused tail reads as stop level
  function automatic logic [7:0] order(input logic [7:0] v, input int c,
                                       input logic m);
    logic [7:0] o;
    for (int i = 0; i < 8; i++)
      o[i] = (i >= c) | (m ? v[7 - i] : v[i]);
    return o;
  endfunction

  // Cycles rounded to whole bit times
  function automatic int bits(input int c);
    return (c + bit_c / 2) / bit_c;
  endfunction

  // Baud change only with the interface powered down
  task automatic speed(input logic [3:0] s, input logic [7:0] b);
    @(negedge clk_i);
    cfg.power_enable = 1'b0;
    cfg.clk_sel = s;
    cfg.baud_divider_control = b;
    bit_c = 16 * (b + 1) * (1 << s);
    u_node.bit_cyc = bit_c;
    last_rx = RX_BUF_RST;
    @(negedge clk_i);
    cfg.power_enable = 1'b1;
  endtask

  // Buffer holds one byte with no read port; rx enable low frees it
  task automatic rx_send(input logic [7:0] b, input int c);
    @(negedge clk_i);
    cfg.rx_enable = 1'b0;
    @(negedge clk_i);
    cfg.rx_enable = 1'b1;
    u_node.send(b, c);
  endtask

  task automatic wait_n(ref int c, input int t);
    for (int i = 0; i < 8000 && c < t; i++) @(negedge clk_i);
  endtask

  task automatic wr(input logic [7:0] v);
    @(negedge clk_i);
    tx_d = v;
    tx_wr = 1'b1;
    @(negedge clk_i);
    tx_wr = 1'b0;
  endtask

  // One frame, then wait for done: no back-to-back here
  task automatic tx(input logic [7:0] v);
    int t;
    t = n_txd + 1;
    wr(v);
    wait_n(n_txd, t);
    check(n_txd, t);
    repeat (bit_c) @(negedge clk_i);
  endtask

  initial begin
    void'($urandom(32'h3c4d2907));
    repeat (12) @(negedge clk_i);
    rstn_i = 1'b1;
    @(negedge clk_i);
    check(tx_pin, 1);
    check(rxb, 8'hFF);
    check(stat, 0);
    cfg.power_enable = 1'b1;
    cfg.tx_enable = 1'b1;
    cfg.rx_enable = 1'b1;
    speed(4'h0, 8'h00);
    // Both lengths and both orders, each direction
    for (int m = 0; m < 4; m++) begin
      cfg.len8 = ~m[0];
      cfg.msb_first = m[1];
      n = m[0] ? 7 : 8;
      d = 8'($urandom);
      tx(d);
      check(u_node.rx_q.pop_front(), order(d, n, m[1]));
      r = n_rx + 1;
      rx_send(order(d, n, m[1]), n);
      last_rx = n == 8 ? d : m[1] ? {d[7:1], 1'b0} : {1'b0, d[6:0]};
      check(n_rx, r);
      check(rxb, last_rx);
    end
    cfg.len8 = 1'b1;
    cfg.msb_first = 1'b0;
    // Break fields of every programmed length
    for (int l = 0; l < 8; l++) begin
      cfg.ctrl_reg = 8'h01 | 8'(l << BRK_LEN_LSB);
      tx(8'h55);
      check(bits(u_node.low_cyc), 13 + l);
    end
    cfg.ctrl_reg = 8'h00;
    u_node.rx_q.delete();
    // Second byte queued while the first is on the line
    k = n_txd + 2;
    wr(8'h00);
    wr(8'h00);
    wait_n(n_txd, k);
    repeat (bit_c) @(negedge clk_i);
    n = u_node.hi_cyc - bit_c;
    check(n >= 2 && n <= 4, 1);
    check(u_node.rx_q.size(), 2);
    u_node.rx_q.delete();
    // Slower prescaler and divider, wakeup character
    speed(4'h2, 8'h02);
    tx(8'h80);
    check(bits(u_node.low_cyc), 8);
    speed(4'h0, 8'h00);
    // Short and minimal low periods in break receive mode
    cfg.brk_rx_mode = 1'b1;
    for (k = 10; k < 12; k++) begin
      n = n_brk;
      r = n_rx;
      u_node.line_o = 1'b0;
      repeat (k * bit_c) @(negedge clk_i);
      check(n_brk - n, 0);
      u_node.line_o = 1'b1;
      repeat (3 * bit_c) @(negedge clk_i);
      check(n_brk - n, k == 11);
      check(n_rx - r, 0);
      check(rxb, last_rx);
      check(stat.framing_error, 0);
    end
    // Receive pin routing to the external interrupt and capture inputs
    isw0 = 1'b1;
    u_node.line_o = 1'b0;
    repeat (4) @(negedge clk_i);
    check({ext_o, cap_o}, 2'b01);
    isw0 = 1'b0;
    isw1 = 1'b1;
    repeat (4) @(negedge clk_i);
    check({ext_o, cap_o}, 2'b10);
    u_node.line_o = 1'b1;
    isw1 = 1'b0;
    cfg.brk_rx_mode = 1'b0;
    repeat (2 * bit_c) @(negedge clk_i);
    // Transmit disabled: write lost, receiver still works
    cfg.tx_enable = 1'b0;
    k = n_txd;
    wr(8'hA5);
    d = 8'($urandom);
    rx_send(d, 8);
    check(n_txd - k, 0);
    check(tx_pin, 1);
    check(rxb, d);
    cfg.tx_enable = 1'b1;
    cfg.tx_invert = 1'b1;
    repeat (3) @(negedge clk_i);
    check(tx_pin, 0);
    cfg.tx_invert = 1'b0;
    // Power and enables dropped together
    cfg.power_enable = 1'b0;
    cfg.tx_enable = 1'b0;
    cfg.rx_enable = 1'b0;
    repeat (3) @(negedge clk_i);
    check(rxb, 8'hFF);
    check(stat, 0);
    finish_test();
  end
endmodule
